/* File: include/sisc_defines.vh */
`ifndef SISC_DEFINES_VH
`define SISC_DEFINES_VH

// Register byte offsets
`define SISC_OFF_CTRL      12'h000
`define SISC_OFF_CLKSEL    12'h004
`define SISC_OFF_MASK      12'h008
`define SISC_OFF_STATUS    12'h00C
`define SISC_OFF_WAKE      12'h010

// Control register fields
`define SISC_CTRL_STANDBY  0
`define SISC_CTRL_WAKESEL  1
`define SISC_CTRL_SUBCLK   2
`define SISC_CTRL_MAINSTOP 3
`define SISC_CTRL_RESET    4'h0

// Clock source select fields
`define SISC_SEL_WATCH     0
`define SISC_SEL_SSER      1
`define SISC_SEL_TMR8      2
`define SISC_SEL_ASER      3
`define SISC_CLKSEL_RESET  4'h0

// Wake cause fields
`define SISC_WK_NMI        0
`define SISC_WK_EXT        1
`define SISC_WK_INT        2
`define SISC_WK_ACK        3
`define SISC_WK_HOLD       4

// Mode codes
`define SISC_MODE_NORMAL   2'h0
`define SISC_MODE_SUB      2'h1
`define SISC_MODE_SUBIDLE  2'h2

`define SISC_MASK_RESET    7'h7F
`define SISC_INT_MASK_RESET 8'hFF

`endif

/* File: src/sisc_wake_detect.v */
`timescale 1ns/10ps
// Wake detector: two-stage synchronisers for asynchronous wake pins
module sisc_wake_detect
#(
    parameter N_EXT = 7
)
(
    input  wire             hclk,
    input  wire             hresetn,
    input  wire             nmi_pin,
    input  wire [N_EXT-1:0] ext_irq_pin,
    output wire             nmi_sync,
    output wire [N_EXT-1:0] ext_irq_sync
);

    reg [N_EXT:0] meta_r;
    reg [N_EXT:0] sync_r;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_r <= {(N_EXT+1){1'b0}};
            sync_r <= {(N_EXT+1){1'b0}};
        end
        else
        begin
            meta_r <= {ext_irq_pin, nmi_pin};
            sync_r <= meta_r;
        end
    end

    assign nmi_sync     = sync_r[0];
    assign ext_irq_sync = sync_r[N_EXT:1];

endmodule

/* File: src/sisc_sub_idle_ctrl.v */
`timescale 1ns/10ps
`include "sisc_defines.vh"

module sisc_sub_idle_ctrl
#(
    parameter N_EXT = 7,
    parameter N_INT = 8
)
(
    input  wire             hclk,
    input  wire             hresetn,
    // Register bus
    input  wire             hsel,
    input  wire [11:0]      haddr,
    input  wire [1:0]       htrans,
    input  wire             hwrite,
    input  wire [2:0]       hsize,
    input  wire [31:0]      hwdata,
    input  wire             hready,
    output reg  [31:0]      hrdata,
    output wire             hreadyout,
    output wire             hresp,
    // Wake sources and core status
    input  wire             nmi_pin,
    input  wire [N_EXT-1:0] ext_irq_pin,
    input  wire [N_INT-1:0] int_irq_req,
    input  wire             cpu_in_isr,
    input  wire [2:0]       cur_isr_prio,
    input  wire [2:0]       wake_prio,
    input  wire             irq_enabled_state,
    // Clock gates and retention controls
    output wire             osc_sub_en,
    output wire             main_osc_en,
    output wire             cpu_clk_en,
    output wire             periph_clk_en,
    output wire             watch_clk_en,
    output wire             sync_serial_clk_en,
    output wire             timer8_clk_en,
    output wire             async_serial_clk_en,
    output wire             port_hold,
    output wire             ram_hold,
    // Mode and wake reporting
    output reg  [1:0]       mode_r,
    output reg              wake_pulse_r,
    output reg              irq_ack_r,
    output reg              irq_branch_r
);

    localparam ST_RUN  = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_WAKE = 2'h2;

    reg  [3:0]       ctrl_r;
    reg  [3:0]       clksel_r;
    reg  [N_EXT-1:0] ext_mask_r;
    reg  [N_INT-1:0] int_mask_r;
    reg  [4:0]       wake_r;
    reg  [1:0]       state_r;
    reg  [1:0]       state_nxt;
    reg              ph_write_r;
    reg  [11:0]      ph_addr_r;
    reg  [31:0]      rd_nxt;

    wire             nmi_s;
    wire [N_EXT-1:0] ext_s;
    wire             ext_wake;
    wire             int_wake;
    wire             any_wake;
    wire             main_stopped;
    wire             in_idle;
    wire             acc;
    wire             hi_prio;
    wire             entry_req;
    wire             wake_now;

    wire [N_EXT-1:0] ext_hit;
    wire [N_INT-1:0] int_hit;

    wire             wr_ctrl;
    wire             wr_clksel;
    wire             wr_mask;

    // Word match of a byte address against a register offset
    function reg_hit;
        input [11:0] a;
        input [11:0] off;
        begin
            reg_hit = (a[11:2] == off[11:2]);
        end
    endfunction

    // Clock enable of a block that may keep running in sub-idle
    function gate_en;
        input idle;
        input keep;
        begin
            gate_en = !idle | keep;
        end
    endfunction

    sisc_wake_detect #(
        .N_EXT        (N_EXT)
    ) u_wake (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .nmi_pin      (nmi_pin),
        .ext_irq_pin  (ext_irq_pin),
        .nmi_sync     (nmi_s),
        .ext_irq_sync (ext_s)
    );

    // One match per external and internal wake source; masked sources are ignored
    genvar g;
    generate
        for (g = 0; g < N_EXT; g = g + 1)
        begin : g_ext
            assign ext_hit[g] = ext_s[g] & ~ext_mask_r[g];
        end
        for (g = 0; g < N_INT; g = g + 1)
        begin : g_int
            assign int_hit[g] = int_irq_req[g] & ~int_mask_r[g];
        end
    endgenerate

    // Wake logic stays on the always-running subclock
    assign ext_wake = |ext_hit;
    assign int_wake = |int_hit;
    assign any_wake = nmi_s | ext_wake | int_wake;
    assign hi_prio  = nmi_s | !cpu_in_isr | (wake_prio < cur_isr_prio);

    assign in_idle      = (state_r == ST_IDLE);
    assign main_stopped = ctrl_r[`SISC_CTRL_MAINSTOP];
    assign wake_now     = in_idle & any_wake;

    // Standby request honoured only with wake-select clear in subclock mode
    assign entry_req = ctrl_r[`SISC_CTRL_STANDBY] & !ctrl_r[`SISC_CTRL_WAKESEL] &
                       ctrl_r[`SISC_CTRL_SUBCLK];

    // Clock gating during sub-idle
    assign osc_sub_en    = 1'b1;
    assign main_osc_en   = !main_stopped;
    assign cpu_clk_en    = !in_idle;
    assign periph_clk_en = !in_idle;
    // Watch timer and sync serial need the main oscillator stopped as well
    assign watch_clk_en  = gate_en(in_idle, main_stopped & clksel_r[`SISC_SEL_WATCH]);
    assign sync_serial_clk_en = gate_en(in_idle, main_stopped & clksel_r[`SISC_SEL_SSER]);
    // Timers and async serial only need their external clock selected
    assign timer8_clk_en = gate_en(in_idle, clksel_r[`SISC_SEL_TMR8]);
    assign async_serial_clk_en = gate_en(in_idle, clksel_r[`SISC_SEL_ASER]);
    assign port_hold     = in_idle;
    assign ram_hold      = in_idle;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign acc       = hsel & hready & htrans[1];

    // Mode and sleep state machine
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
            begin
                // Only taken from subclock operation
                if (entry_req)
                    state_nxt = ST_IDLE;
            end
            ST_IDLE:
            begin
                // Any unmasked request wakes, whatever its priority
                if (any_wake)
                    state_nxt = ST_WAKE;
            end
            ST_WAKE:
                state_nxt = ST_RUN;
            default:
                state_nxt = ST_RUN;
        endcase
    end

    // State register; reset returns everything to normal mode
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_r <= ST_RUN;
        else
            state_r <= state_nxt;
    end

    // Operating mode: an interrupt wake goes back to subclock
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mode_r <= `SISC_MODE_NORMAL;
        else if (state_nxt == ST_IDLE)
            mode_r <= `SISC_MODE_SUBIDLE;
        else if (ctrl_r[`SISC_CTRL_SUBCLK])
            mode_r <= `SISC_MODE_SUB;
        else
            mode_r <= `SISC_MODE_NORMAL;
    end

    // One-cycle wake, acknowledge and branch pulses
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wake_pulse_r <= 1'b0;
            irq_ack_r    <= 1'b0;
            irq_branch_r <= 1'b0;
        end
        else
        begin
            wake_pulse_r <= wake_now;
            irq_ack_r    <= wake_now & hi_prio;
            irq_branch_r <= wake_now & hi_prio & (nmi_s | irq_enabled_state);
        end
    end

    // Wake cause, kept until the next wake; a refused request sets the hold bit
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wake_r <= 5'h00;
        else if (wake_now)
            wake_r <= {!hi_prio, hi_prio, int_wake, ext_wake, nmi_s};
    end

    // Data phase write strobes, one per writable register
    assign wr_ctrl   = ph_write_r & reg_hit(ph_addr_r, `SISC_OFF_CTRL);
    assign wr_clksel = ph_write_r & reg_hit(ph_addr_r, `SISC_OFF_CLKSEL);
    assign wr_mask   = ph_write_r & reg_hit(ph_addr_r, `SISC_OFF_MASK);

    // AHB-Lite address phase capture
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_write_r <= 1'b0;
            ph_addr_r  <= 12'h000;
        end
        else
        begin
            ph_write_r <= acc & hwrite;
            if (acc)
            begin
                ph_addr_r <= haddr;
            end
        end
    end

    // Control register; the standby request self-clears once sub-idle is taken
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_r <= `SISC_CTRL_RESET;
        else if (wr_ctrl)
            ctrl_r <= hwdata[3:0];
        else if (state_nxt == ST_IDLE)
            ctrl_r[`SISC_CTRL_STANDBY] <= 1'b0;
    end

    // Clock source selection for blocks that may run in sub-idle
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            clksel_r <= `SISC_CLKSEL_RESET;
        else if (wr_clksel)
            clksel_r <= hwdata[3:0];
    end

    // Wake masks, a one masks the source
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_mask_r <= `SISC_MASK_RESET;
            int_mask_r <= `SISC_INT_MASK_RESET;
        end
        else if (wr_mask)
        begin
            ext_mask_r <= hwdata[N_EXT-1:0];
            int_mask_r <= hwdata[N_INT+15:16];
        end
    end

    // Read data is taken in the address phase and stands until the next read
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (acc && !hwrite)
            hrdata <= rd_nxt;
    end

    // Read mux; unmapped offsets read zero

    always @*
    begin
        rd_nxt = 32'h00000000;
        if (reg_hit(haddr, `SISC_OFF_CTRL))
            rd_nxt[3:0] = ctrl_r;
        else if (reg_hit(haddr, `SISC_OFF_CLKSEL))
            rd_nxt[3:0] = clksel_r;
        else if (reg_hit(haddr, `SISC_OFF_MASK))
        begin
            rd_nxt[N_EXT-1:0]  = ext_mask_r;
            rd_nxt[N_INT+15:16] = int_mask_r;
        end
        else if (reg_hit(haddr, `SISC_OFF_STATUS))
            rd_nxt[1:0] = state_r;
        else if (reg_hit(haddr, `SISC_OFF_WAKE))
            rd_nxt[4:0] = wake_r;
    end

endmodule

/* File: sim/sisc_assertions.sv */
`timescale 1ns/10ps
module sisc_chk
(
    input wire       hclk,
    input wire       hresetn,
    input wire       nmi_pin,
    input wire [1:0] mode_r,
    input wire       wake_pulse_r,
    input wire       irq_ack_r,
    input wire       irq_branch_r,
    input wire       cpu_clk_en,
    input wire       periph_clk_en,
    input wire       osc_sub_en,
    input wire       port_hold,
    input wire       ram_hold
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_gate; mode_r == 2'h2 |-> !cpu_clk_en && !periph_clk_en && osc_sub_en; endproperty
    a_gate: assert property (p_gate) else $error("gating wrong");
    property p_hold; mode_r == 2'h2 |-> port_hold && ram_hold; endproperty
    a_hold: assert property (p_hold) else $error("hold missing");
    property p_nmi; $rose(nmi_pin) && mode_r == 2'h2 |-> ##[1:4] wake_pulse_r; endproperty
    a_nmi: assert property (p_nmi) else $error("no nmi wake");
    property p_back; wake_pulse_r |-> ##[0:2] mode_r == 2'h1; endproperty
    a_back: assert property (p_back) else $error("not back in subclock");
    property p_ack; irq_ack_r |-> wake_pulse_r; endproperty
    a_ack: assert property (p_ack) else $error("ack without wake");
    property p_branch; irq_branch_r |-> irq_ack_r; endproperty
    a_branch: assert property (p_branch) else $error("branch without ack");
    property p_rst; !$past(hresetn) |-> mode_r == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("not normal after reset");
    property p_entry; mode_r == 2'h2 && $past(mode_r) != 2'h2 |-> $past(mode_r) == 2'h1; endproperty
    a_entry: assert property (p_entry) else $error("entry not from subclock");
endmodule
bind sisc_sub_idle_ctrl sisc_chk u_chk (.*);

/* File: sim/sisc_cpu_model.sv */
`timescale 1ns/10ps
module sisc_cpu_model
(
    input  wire       hclk,
    input  wire [7:0] cfg,
    input  wire [7:0] ireq,
    output reg        cpu_in_isr,
    output reg  [2:0] cur_isr_prio,
    output reg  [2:0] wake_prio,
    output reg        irq_enabled_state,
    output reg  [7:0] int_irq_req
);
    // Core status and peripheral requests change just after the edge
    always @(posedge hclk)
    begin
        {irq_enabled_state, wake_prio, cur_isr_prio, cpu_in_isr} <= cfg;
        int_irq_req <= ireq;
    end
endmodule

/* File: sim/sub_idle_standby_control_tb_top.sv */
`timescale 1ns/10ps
module sub_idle_standby_control_tb_top;
    reg         hclk = 0;
    reg         hresetn = 0;
    reg         hsel = 0;
    reg  [11:0] haddr = 12'h000;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 0;
    reg  [31:0] hwdata = 32'h0;
    reg         nmi_pin = 0;
    reg  [6:0]  ext_irq_pin = 7'h00;
    reg  [7:0]  cfg = 8'h00;
    reg  [7:0]  ireq = 8'h00;
    reg  [31:0] r = 32'h3761;
    reg  [31:0] q;
    reg         e;
    integer     mismatches = 0;
    integer     check_count = 0;
    integer     cyc = 0;
    integer     i, n, k;
    wire [31:0] hrdata;
    wire [1:0]  mode_r;
    wire [2:0]  cur_isr_prio, wake_prio;
    wire [7:0]  int_irq_req;
    wire        hreadyout, hresp, osc_sub_en, main_osc_en, cpu_clk_en, periph_clk_en, watch_clk_en;
    wire        sync_serial_clk_en, timer8_clk_en, async_serial_clk_en, port_hold, ram_hold;
    wire        wake_pulse_r, irq_ack_r, irq_branch_r, cpu_in_isr, irq_enabled_state;
    wire        hready = hreadyout;
    sisc_sub_idle_ctrl u_dut (.*, .hsize(3'h2));
    sisc_cpu_model u_cpu (.*);
    always #12.5 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            mismatches = mismatches + 1;
            stop_test;
        end
    end
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    task chk(input [31:0] g, input [31:0] x);
        begin
            check_count = check_count + 1;
            if (g !== x)
            begin
                mismatches = mismatches + 1;
                $display("BAD %0t got %h exp %h", $time, g, x);
            end
        end
    endtask
    task ahb(input [11:0] a, input w, input [31:0] d);
        begin
            hsel <= 1;
            haddr <= a;
            hwrite <= w;
            htrans <= 2'h2;
            @(posedge hclk);
            while (hready !== 1'b1) @(posedge hclk);
            htrans <= 2'h0;
            hsel <= 0;
            hwdata <= d;
            @(posedge hclk);
            while (hready !== 1'b1) @(posedge hclk);
            q = hrdata;
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, mismatches);
            if (mismatches == 0 && check_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        ahb(12'h008, 0, 32'h0);
        chk(q, 32'h00FF007F);
        ahb(12'h020, 1, 32'hFFFFFFFF);
        ahb(12'h020, 0, 32'h0);
        chk(q, 32'h0);
        chk(hresp, 1'b0);
        ahb(12'h000, 1, 32'h7);
        repeat (2) @(posedge hclk);
        chk(mode_r, 2'h1);
        ahb(12'h008, 1, 32'h0);
        for (i = 0; i < 40; i = i + 1)
        begin
            r = xs(r);
            cfg <= r[7:0];
            ahb(12'h004, 1, {28'h0, r[11:8]});
            ahb(12'h000, 1, {28'h0, r[12], 3'h5});
            repeat (2) @(posedge hclk);
            chk(mode_r, 2'h2);
            chk({timer8_clk_en, async_serial_clk_en}, {r[10], r[11]});
            chk({watch_clk_en, sync_serial_clk_en, main_osc_en}, {r[8] & r[12], r[9] & r[12], !r[12]});
            k = r[15:13] % 3;
            if (k == 0)
                nmi_pin <= 1;
            else if (k == 1)
                ext_irq_pin[r[18:16] % 7] <= 1;
            else
                ireq[r[18:16]] <= 1;
            n = 0;
            while (wake_pulse_r !== 1'b1 && n < 8)
            begin
                @(posedge hclk);
                n = n + 1;
            end
            e = (k == 0) | !cfg[0] | (cfg[6:4] < cfg[3:1]);
            chk(wake_pulse_r, 1'b1);
            chk({irq_ack_r, irq_branch_r}, {e, e & ((k == 0) | cfg[7])});
            nmi_pin <= 0;
            ext_irq_pin <= 7'h00;
            ireq <= 8'h00;
            repeat (4) @(posedge hclk);
            chk(mode_r, 2'h1);
        end
        ahb(12'h008, 1, 32'h00FF007F);
        ahb(12'h000, 1, 32'h5);
        ext_irq_pin <= 7'h7F;
        repeat (8) @(posedge hclk);
        chk(mode_r, 2'h2);
        hresetn <= 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        chk(mode_r, 2'h0);
        ahb(12'h000, 0, 32'h0);
        chk(q, 32'h0);
        stop_test;
    end
endmodule
